/* File: rtl/dcr_cmd.sv */
/*
  command decoder and burst engine: reads, writes, precharge, refresh
  and self refresh over eight tracked banks and a small data array.
  assumes command pins are synchronous to clk, one data beat per clock,
  and that the controller keeps its own timing duties.
*/
`timescale 1ns/10ps
`include "dcr_defs.svh"
module dcr_cmd #(
  parameter int DW    = 16,
  parameter int COL_W = 6,
  parameter int RW    = 13
)(
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        ce,
  input  wire logic                        cke,
  input  wire logic                        cs_n,
  input  wire logic                        ras_n,
  input  wire logic                        cas_n,
  input  wire logic                        we_n,
  input  wire logic [`DCR_BA_W-1:0]        ba,
  input  wire logic [`DCR_AW-1:0]          addr,
  input  wire logic [DW-1:0]               wdata,
  input  wire logic [DW/8-1:0]             write_byte_mask,
  input  wire logic                        per_command_size_select,
  input  wire logic                        fixed_chop,
  input  wire logic                        interleave,
  output logic      [DW-1:0]               rdata,
  output logic                             rvalid,
  output logic                             wbeat,
  output dcr_pkg::dcr_burst_t              burst_phase,
  output logic      [2*`DCR_BANKS-1:0]     bank_state,
  output logic                             refresh_busy,
  output logic                             self_refresh,
  output logic      [RW-1:0]               refresh_row,
  output logic                             illegal_cmd
);
  import dcr_pkg::*;
  localparam int NB     = `DCR_BANKS;
  localparam int REFC   = `DCR_REF_CYC;
  localparam int TREFI  = `DCR_TREFI_CYC;
  localparam int FW     = $clog2(REFC + 1);
  localparam int SW     = $clog2(TREFI + 1);
  localparam int MAW    = `DCR_BA_W + COL_W;

  // ---------------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------------
  logic                  cke_prev_r;
  logic                  self_r;
  dcr_cmd_t              cmd;
  wire [2:0]             rcw = {ras_n, cas_n, we_n};

  assign cmd = cs_n          ? CMD_DES :
               (rcw == 3'h7) ? CMD_NOP :
               (rcw == 3'h3) ? CMD_ACT :
               (rcw == 3'h5) ? CMD_RD  :
               (rcw == 3'h4) ? CMD_WR  :
               (rcw == 3'h2) ? CMD_PRE :
               (rcw == 3'h1) ? CMD_REF : CMD_OTHER;

  wire cmd_live = cke_prev_r && cke && !self_r;
  wire rd_req   = cmd_live && (cmd == CMD_RD);
  wire wr_req   = cmd_live && (cmd == CMD_WR);
  wire act_req  = cmd_live && (cmd == CMD_ACT);
  wire pre_req  = cmd_live && (cmd == CMD_PRE);
  wire ref_req  = cmd_live && (cmd == CMD_REF);
  wire quiet    = (cmd == CMD_DES) || (cmd == CMD_NOP);

  // ---------------------------------------------------------------------
  // bank trackers
  // ---------------------------------------------------------------------
  dcr_bank_t             bst [NB];
  logic [NB-1:0]         bk_open;
  logic [NB-1:0]         bk_idle;
  logic [NB-1:0]         act_vec;
  logic [NB-1:0]         close_vec;
  wire  [NB-1:0]         ba_hot = NB'(1) << ba;

  for (genvar g = 0; g < NB; g++) begin : g_bank
    dcr_bank #(
      .PRE_CYC (`DCR_PRE_CYC)
    ) u_bank (
      .clk       (clk),
      .rst       (rst),
      .ce        (ce),
      .open_req  (act_vec[g]),
      .close_req (close_vec[g]),
      .state     (bst[g])
    );
    assign bk_open[g]          = (bst[g] == BK_OPEN);
    assign bk_idle[g]          = (bst[g] == BK_IDLE);
    assign bank_state[2*g +: 2] = bst[g];
  end

  // ---------------------------------------------------------------------
  // burst state
  // ---------------------------------------------------------------------
  dcr_burst_t            burst_r;
  logic [2:0]            beat_r;
  logic [2:0]            start_r;
  logic [COL_W-4:0]      colhi_r;
  logic [`DCR_BA_W-1:0]  bank_r;
  logic                  chop_r;
  logic                  ap_r;
  logic                  ilv_r;
  logic [FW-1:0]         ref_cnt_r;
  logic [SW-1:0]         sr_cnt_r;
  logic                  illegal_r;
  logic                  rvalid_r;

  wire burst_idle = (burst_r == BU_IDLE);
  wire ref_busy   = (ref_cnt_r != '0);
  wire last_beat  = (beat_r == (chop_r ? `DCR_LAST4 : `DCR_LAST8));
  wire burst_end  = !burst_idle && last_beat;
  wire all_idle   = &bk_idle;

  // per-command size only when enabled, else the fixed setting
  wire chop_sel   = per_command_size_select ? !addr[`DCR_A_BC]
                                            : fixed_chop;
  wire rdwr_ok    = (rd_req || wr_req) && bk_open[ba]
                    && burst_idle && !ref_busy;
  wire act_ok     = act_req && bk_idle[ba] && !ref_busy;
  wire ref_ok     = ref_req && all_idle && burst_idle && !ref_busy;
  wire sre_ok     = cke_prev_r && !cke && !self_r && !cs_n
                    && (cmd == CMD_REF) && all_idle && burst_idle
                    && !ref_busy;
  wire srx        = self_r && cke && quiet;
  wire sr_tick    = self_r && (sr_cnt_r == SW'(TREFI - 1));

  wire [NB-1:0] ap_close  = (burst_end && ap_r) ? (NB'(1) << bank_r)
                                                : '0;
  wire [NB-1:0] pre_close = !pre_req ? '0 :
                            addr[`DCR_A_AP] ? '1 : ba_hot;

  assign act_vec   = act_ok ? ba_hot : '0;
  assign close_vec = pre_close | ap_close;

  wire bad = ((rd_req || wr_req) && !rdwr_ok)
             || (act_req && !act_ok)
             || (ref_req && !ref_ok)
             || (cmd_live && ref_busy && !quiet);

  // burst column order within the eight-column block
  wire [2:0] col_seq8 = start_r + beat_r;
  wire [2:0] col_seq4 = {start_r[2], start_r[1:0] + beat_r[1:0]};
  wire [2:0] col_ilv  = start_r ^ beat_r;
  wire [2:0] beat_col = ilv_r  ? col_ilv  :
                        chop_r ? col_seq4 : col_seq8;

  wire [MAW-1:0]  mem_addr = {bank_r, colhi_r, beat_col};
  wire            mem_we   = (burst_r == BU_WR);
  wire [DW/8-1:0] mem_be   = ~write_byte_mask;

  // ---------------------------------------------------------------------
  // clock enable history and self refresh
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      cke_prev_r <= 1'b0;
      self_r     <= 1'b0;
    end else if (ce) begin
      cke_prev_r <= cke;
      if (sre_ok) self_r <= 1'b1;
      else if (srx) self_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // refresh timing and row counter
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ref_cnt_r   <= '0;
      sr_cnt_r    <= '0;
      refresh_row <= '0;
    end else if (ce) begin
      if (ref_ok) ref_cnt_r <= FW'(REFC);
      else if (ref_busy) ref_cnt_r <= ref_cnt_r - 1'b1;
      if (!self_r || sr_tick) sr_cnt_r <= '0;
      else sr_cnt_r <= sr_cnt_r + 1'b1;
      if (ref_ok || sr_tick) refresh_row <= refresh_row + 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // burst engine
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      burst_r <= BU_IDLE;
      beat_r  <= '0;
    end else if (ce) begin
      if (rdwr_ok) begin
        burst_r <= rd_req ? BU_RD : BU_WR;
        beat_r  <= '0;
      end else if (burst_end) begin
        burst_r <= BU_IDLE;
        beat_r  <= '0;
      end else if (!burst_idle) begin
        beat_r  <= beat_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      start_r <= '0;
      colhi_r <= '0;
      bank_r  <= '0;
      chop_r  <= 1'b0;
      ap_r    <= 1'b0;
      ilv_r   <= 1'b0;
    end else if (ce && rdwr_ok) begin
      start_r <= addr[2:0];
      colhi_r <= addr[COL_W-1:3];
      bank_r  <= ba;
      chop_r  <= chop_sel;
      ap_r    <= addr[`DCR_A_AP];
      ilv_r   <= interleave;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      illegal_r <= 1'b0;
      rvalid_r  <= 1'b0;
    end else if (ce) begin
      illegal_r <= bad;
      rvalid_r  <= (burst_r == BU_RD);
    end
  end

  // ---------------------------------------------------------------------
  // data array
  // ---------------------------------------------------------------------
  dcr_mem #(
    .AW (MAW),
    .DW (DW)
  ) u_mem (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .we    (mem_we),
    .be    (mem_be),
    .addr  (mem_addr),
    .wdata (wdata),
    .rdata (rdata)
  );

  assign rvalid       = rvalid_r;
  assign wbeat        = mem_we;
  assign burst_phase  = burst_r;
  assign refresh_busy = ref_busy;
  assign self_refresh = self_r;
  assign illegal_cmd  = illegal_r;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  a_read_first_col: assert property (@(posedge clk) disable iff (rst)
    ce && rdwr_ok && rd_req
    |=> burst_r == BU_RD && beat_r == 3'h0
        && beat_col == $past(addr[2:0]) && bank_r == $past(ba))
    else $error("read burst did not start at the addressed column");

  a_idle_bank_reject: assert property (@(posedge clk) disable iff (rst)
    ce && (rd_req || wr_req) && !bk_open[ba]
    |=> illegal_r && burst_r == $past(burst_r))
    else $error("access to a closed bank was not rejected");

  a_chop_length: assert property (@(posedge clk) disable iff (rst)
    !burst_idle && chop_r |-> beat_r <= `DCR_LAST4)
    else $error("chopped burst ran past four beats");

  a_autoclose_bank: assert property (@(posedge clk) disable iff (rst)
    ce && burst_end && ap_r |=> bst[$past(bank_r)] == BK_PRE)
    else $error("auto close did not precharge the burst bank");

  a_mask_gates_byte: assert property (@(posedge clk) disable iff (rst)
    ce && mem_we && write_byte_mask[DW/8-1]
    |=> u_mem.mem_r[$past(mem_addr)][DW-1 -: 8]
        == $past(u_mem.mem_r[mem_addr][DW-1 -: 8]))
    else $error("masked write byte was changed");

  a_close_all_banks: assert property (@(posedge clk) disable iff (rst)
    ce && pre_req && addr[`DCR_A_AP] |=> bk_open == '0)
    else $error("precharge all left a bank open");

  a_refresh_row_step: assert property (@(posedge clk) disable iff (rst)
    ce && ref_ok
    |=> ref_busy && refresh_row == $past(refresh_row) + 1'b1)
    else $error("refresh did not start or step the row counter");

  a_self_exit: assert property (@(posedge clk) disable iff (rst)
    ce && srx |=> !self_r ##1 !self_r || !cke_prev_r || sre_ok)
    else $error("self refresh did not end on clock enable high");
endmodule

/* File: inc/dcr_defs.svh */
/*
  constants for the command decoder: address bit positions, burst
  lengths, timing figures and the cycle counts derived from them.
  assumes a 50 MHz core clock and an eight-bank array.
*/
// Function
// - read to an open bank starts a burst; low column bits pick start
// - address bit ten on a read closes the row after the burst
// - with per-command sizing, bit twelve low chops to four, high gives eight
// - read is cke high before, cs low, ras high, cas low, we high
// - write to an open bank starts a burst to the addressed bank
// - write is encoded like a read but with we low
// - a write byte is stored only when its mask is low with the data
// - precharge closes one or all banks; reopen waits the precharge period
// - bit ten high closes all banks, low closes the addressed bank only
// - reads and writes to an idle bank are rejected
// - precharge to idle or closing bank is a no-op; period restarts
// - each refresh uses the internal row counter; address is ignored
// - self refresh keeps contents by refreshing internally
// - commands decode from cs, ras, cas, we and cke at a rising edge
// - deselect starts nothing; running operations carry on
// - self refresh ends when cke returns high with deselect or no-op
`ifndef DCR_DEFS_SVH
`define DCR_DEFS_SVH

// -----------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------
`define DCR_BANKS     8
`define DCR_BA_W      3
`define DCR_AW        14
`define DCR_A_AP      10
`define DCR_A_BC      12
`define DCR_LAST8     3'h7
`define DCR_LAST4     3'h3

// -----------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------
`define DCR_CLK_NS    20
`define DCR_PRE_NS    15
`define DCR_REF_NS    160
`define DCR_TREFI_NS  7800
`define DCR_PRE_CYC   ((`DCR_PRE_NS + `DCR_CLK_NS - 1) / `DCR_CLK_NS)
`define DCR_REF_CYC   ((`DCR_REF_NS + `DCR_CLK_NS - 1) / `DCR_CLK_NS)
`define DCR_TREFI_CYC (`DCR_TREFI_NS / `DCR_CLK_NS)

`endif

/* File: inc/dcr_pkg.sv */
/*
  types shared by the command decoder, the bank tracker and the bench.
  assumes nothing beyond a SystemVerilog tool.
*/
package dcr_pkg;
  typedef enum logic [1:0] {BK_IDLE, BK_OPEN, BK_PRE} dcr_bank_t;
  typedef enum logic [2:0] {CMD_DES, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR,
                            CMD_PRE, CMD_REF, CMD_OTHER} dcr_cmd_t;
  typedef enum logic [1:0] {BU_IDLE, BU_RD, BU_WR} dcr_burst_t;
endpackage

/* File: rtl/dcr_bank.sv */
/*
  state of one bank: idle, open or closing, with the precharge timer.
  assumes open requests come already checked by the decoder; close requests are not.
*/
`timescale 1ns/10ps
module dcr_bank #(
  parameter int PRE_CYC = 1
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        open_req,
  input  wire logic        close_req,
  output dcr_pkg::dcr_bank_t state
);
  import dcr_pkg::*;
  localparam int TW = $clog2(PRE_CYC + 1);
  localparam logic [TW-1:0] PRE_LD = TW'(PRE_CYC);

  dcr_bank_t       state_r;
  logic [TW-1:0]   cnt_r;

  assign state = state_r;

  // ---------------------------------------------------------------------
  // bank state
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= BK_IDLE;
      cnt_r   <= '0;
    end else if (ce) begin
      case (state_r)
        BK_IDLE: begin
          if (open_req) state_r <= BK_OPEN;
        end
        BK_OPEN: begin
          if (close_req) begin
            state_r <= BK_PRE;
            cnt_r   <= PRE_LD;
          end
        end
        BK_PRE: begin
          if (close_req) begin
            cnt_r <= PRE_LD;
          end else if (cnt_r <= 1) begin
            state_r <= BK_IDLE;
            cnt_r   <= '0;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: state_r <= BK_IDLE;
      endcase
    end
  end

  a_close_starts_timer: assert property (@(posedge clk) disable iff (rst)
    ce && state_r == BK_OPEN && close_req
    |=> state_r == BK_PRE && cnt_r == PRE_LD)
    else $error("closing bank did not load the precharge period");

  a_idle_close_nop: assert property (@(posedge clk) disable iff (rst)
    ce && state_r == BK_IDLE && close_req && !open_req
    |=> state_r == BK_IDLE)
    else $error("precharge to an idle bank changed its state");
endmodule

/* File: rtl/dcr_mem.sv */
/*
  small byte-maskable data array with registered read data.
  assumes one access per enabled clock; contents are not reset.
*/
`timescale 1ns/10ps
module dcr_mem #(
  parameter int AW = 9,
  parameter int DW = 16
)(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              we,
  input  wire logic [DW/8-1:0]   be,
  input  wire logic [AW-1:0]     addr,
  input  wire logic [DW-1:0]     wdata,
  output logic      [DW-1:0]     rdata
);
  logic [DW-1:0] mem_r [2**AW];

  // ---------------------------------------------------------------------
  // array write and registered read
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (ce && we) begin
      for (int i = 0; i < DW/8; i++) begin
        if (be[i]) mem_r[addr][i*8 +: 8] <= wdata[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) rdata <= '0;
    else if (ce) rdata <= mem_r[addr];
  end
endmodule

/* File: sim/dcr_ctl_model.sv */
/*
  controller-side model: drives command pins, write beats and masks.
  assumes one command per call, nop between commands, data paced by wbeat.
*/
`timescale 1ns/10ps
module dcr_ctl_model (
  input  wire logic        clk,
  input  wire logic        wbeat,
  output logic             cke,
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic [2:0]       ba,
  output logic [13:0]      addr,
  output logic [15:0]      wdata,
  output logic [1:0]       write_byte_mask
);
  logic [15:0] wq [8];
  logic [1:0]  mq [8];
  logic [2:0]  bi;

  initial begin
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    ba = 3'h0;
    addr = 14'h0000;
    wdata = 16'h0000;
    write_byte_mask = 2'h0;
    bi = 3'h0;
  end

  // -----------------------------------------------------------------------
  // command issue
  // -----------------------------------------------------------------------
  // cke stays high around every command from cmd; sr_enter lowers it with the self refresh entry command
  task automatic cmd(input logic [3:0] c, input logic [2:0] b,
                     input logic [13:0] a);
    @(posedge clk);
    {cs_n, ras_n, cas_n, we_n} <= c;
    ba <= b;
    addr <= a;
    @(posedge clk);
    {cs_n, ras_n, cas_n, we_n} <= 4'h7;
    ba <= ~b;
    addr <= ~a;
  endtask

  task automatic put(input int k, input logic [15:0] d, input logic [1:0] m);
    wq[k] = d;
    mq[k] = m;
  endtask

  task automatic wr(input logic [2:0] b, input logic [13:0] a);
    bi <= 3'h0;
    wdata <= wq[0];
    write_byte_mask <= mq[0];
    cmd(4'h4, b, a);
  endtask

  task automatic sr_enter;
    @(posedge clk);
    cke <= 1'b0;
    {cs_n, ras_n, cas_n, we_n} <= 4'h1;
    @(posedge clk);
    {cs_n, ras_n, cas_n, we_n} <= 4'h7;
  endtask

  task automatic sr_exit;
    @(posedge clk);
    cke <= 1'b1;
  endtask

  // -----------------------------------------------------------------------
  // write beats: next beat put out once the current one is taken
  // -----------------------------------------------------------------------
  always @(posedge clk) begin
    if (wbeat === 1'b1) begin
      bi <= bi + 3'h1;
      wdata <= wq[bi + 3'h1];
      write_byte_mask <= mq[bi + 3'h1];
    end
  end
endmodule

/* File: sim/dcr_cmd_tb_top.sv */
/*
  self-checking bench for the command decoder: bursts, masks, precharge,
  refresh and self refresh driven through the controller model.
  assumes the design package and defines header are compiled first.
*/
`timescale 1ns/10ps
module ddr3_rw_precharge_refresh_cmds_tb_top;
  import dcr_pkg::*;
  logic        clk, rst, ce, pcs, fchop, il;
  logic        cke, cs_n, ras_n, cas_n, we_n, wbeat, rvalid, illegal_cmd;
  logic        refresh_busy, self_refresh;
  logic [2:0]  ba;
  logic [13:0] addr;
  logic [15:0] wdata, rdata, bank_state;
  logic [1:0]  write_byte_mask;
  logic [12:0] refresh_row, r0;
  dcr_burst_t  burst_phase;
  int          fail_count, checked, n;
  logic [15:0] rq [$];

  dcr_ctl_model m (.clk(clk), .wbeat(wbeat), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
    .wdata(wdata), .write_byte_mask(write_byte_mask));

  dcr_cmd uut (.clk(clk), .rst(rst), .ce(ce), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
    .wdata(wdata), .write_byte_mask(write_byte_mask),
    .per_command_size_select(pcs), .fixed_chop(fchop), .interleave(il),
    .rdata(rdata), .rvalid(rvalid), .wbeat(wbeat),
    .burst_phase(burst_phase), .bank_state(bank_state),
    .refresh_busy(refresh_busy), .self_refresh(self_refresh),
    .refresh_row(refresh_row), .illegal_cmd(illegal_cmd));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (rvalid === 1'b1) begin
      rq.push_back(rdata);
    end
  end

  // -----------------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // stored word per column after the two writes; beat 2 high byte kept
  function automatic logic [15:0] expd(input int c);
    return (c == 2) ? 16'hff32 : {8'h0a, 8'h30 + 8'(c)};
  endfunction

  function automatic int col(input int s, input int b, input bit ch,
                             input bit iv);
    if (iv) return s ^ b;
    if (ch) return (s & 4) | ((s + b) & 3);
    return (s + b) & 7;
  endfunction

  // no new command until the burst is over
  task automatic wait_idle;
    int i;
    repeat (2) @(posedge clk);
    for (i = 0; i < 30 && burst_phase !== BU_IDLE; i++) @(posedge clk);
    if (i == 30) chk(16'h0001, 16'h0000, "burst never ended");
    repeat (2) @(posedge clk);
  endtask

  task automatic bk(input int g, input dcr_bank_t s, input string what);
    chk({14'h0000, bank_state[2*g +: 2]}, {14'h0000, s}, what);
  endtask

  task automatic rd_check(input int s, input bit ch, input bit iv,
                          input bit a10, input bit a12);
    int b;
    rq.delete();
    il <= iv;
    m.cmd(4'h5, 3'h0, {1'b0, a12, 1'b0, a10, 7'h00, 3'(s)});
    wait_idle();
    chk(16'(rq.size()), ch ? 16'h0004 : 16'h0008, "beat count");
    for (b = 0; b < rq.size(); b++) begin
      chk(rq[b], expd(col(s, b, ch, iv)), "read word");
    end
  endtask

  // -----------------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    pcs = 1'b1;
    fchop = 1'b0;
    il = 1'b0;
    fail_count = 0;
    checked = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    m.cmd(4'h3, 3'h0, 14'h0000);
    for (int k = 0; k < 8; k++) m.put(k, {8'hff, 8'(k)}, 2'b00);
    m.wr(3'h0, 14'h1000);
    wait_idle();
    for (int k = 0; k < 8; k++)
      m.put(k, {8'h0a, 8'h30 + 8'(k)}, (k == 2) ? 2'b10 : 2'b00);
    m.wr(3'h0, 14'h1000);
    wait_idle();
    rd_check(0, 1'b0, 1'b0, 1'b0, 1'b1);
    $display("test write and masked read done");
    rd_check(3, 1'b0, 1'b1, 1'b0, 1'b1);
    rd_check(5, 1'b1, 1'b0, 1'b0, 1'b0);
    pcs <= 1'b0;
    fchop <= 1'b1;
    rd_check(6, 1'b1, 1'b0, 1'b0, 1'b1);
    pcs <= 1'b1;
    rd_check(1, 1'b0, 1'b0, 1'b1, 1'b1);
    bk(0, BK_IDLE, "bank 0 after auto close");
    $display("test burst order and size done");
    m.cmd(4'h5, 3'h0, 14'h1000);
    @(posedge clk);
    chk({15'h0000, illegal_cmd}, 16'h0001, "read idle bank");
    m.cmd(4'hd, 3'h0, 14'h1000);
    @(posedge clk);
    chk({15'h0000, illegal_cmd}, 16'h0000, "deselect flagged");
    chk({14'h0000, burst_phase}, {14'h0000, BU_IDLE}, "deselect ran");
    $display("test refusal done");
    m.cmd(4'h3, 3'h1, 14'h0000);
    m.cmd(4'h3, 3'h2, 14'h0000);
    @(posedge clk);
    bk(1, BK_OPEN, "bank 1 open");
    m.cmd(4'h2, 3'h1, 14'h0000);
    @(posedge clk);
    bk(1, BK_PRE, "bank 1 closing");
    bk(2, BK_OPEN, "bank 2 kept");
    m.cmd(4'h2, 3'h3, 14'h0000);
    @(posedge clk);
    bk(3, BK_IDLE, "idle bank precharged");
    chk({15'h0000, illegal_cmd}, 16'h0000, "precharge idle flagged");
    bk(1, BK_IDLE, "bank 1 back idle");
    m.cmd(4'h2, 3'h1, 14'h0400);
    @(posedge clk);
    bk(2, BK_PRE, "bank 2 closing by all");
    repeat (2) @(posedge clk);
    chk(bank_state, 16'h0000, "all banks idle");
    $display("test precharge done");
    r0 = refresh_row;
    // refresh given with all address bits high; the row counter must still step by one
    m.cmd(4'h1, 3'h5, 14'h3fff);
    @(posedge clk);
    n = 0;
    while (refresh_busy === 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    chk(16'(n), 16'h0008, "refresh cycle length");
    chk({3'h0, refresh_row}, {3'h0, r0 + 13'h0001}, "refresh row");
    $display("test refresh done");
    m.cmd(4'h3, 3'h4, 14'h0000);
    m.cmd(4'h3, 3'h5, 14'h0000);
    m.cmd(4'h5, 3'h4, 14'h1400);
    repeat (7) @(posedge clk);
    m.cmd(4'h5, 3'h5, 14'h1400);
    bk(4, BK_PRE, "bank 4 closing");
    @(posedge clk);
    chk({15'h0000, illegal_cmd}, 16'h0000, "read beside closing");
    chk({14'h0000, burst_phase}, {14'h0000, BU_RD}, "bank 5 read");
    wait_idle();
    chk(bank_state, 16'h0000, "auto close banks idle");
    $display("test concurrent auto close done");
    r0 = refresh_row;
    m.sr_enter();
    @(posedge clk);
    chk({15'h0000, self_refresh}, 16'h0001, "self refresh entry");
    repeat (400) @(posedge clk);
    chk({3'h0, refresh_row}, {3'h0, r0 + 13'h0001}, "internal refresh");
    m.sr_exit();
    repeat (2) @(posedge clk);
    chk({15'h0000, self_refresh}, 16'h0000, "self refresh exit");
    $display("test self refresh done");
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
